// ---- icsf_pkg.sv ----
// Package for the interrupt control and status flag block.
// Assumes one 25 MHz clock domain and a synchronous active-high reset.
package icsf_pkg;
  // ************************************************************
  // Register map and fields
  // ************************************************************
  localparam logic [7:0] ICSF_ADDR_STATUS = 8'h0a;
  localparam logic [7:0] ICSF_ADDR_IRQ_CONTROL = 8'h0b;
  localparam int ICSF_B_C = 0;
  localparam int ICSF_B_AC = 1;
  localparam int ICSF_B_Z = 2;
  localparam int ICSF_B_OV = 3;
  localparam int ICSF_B_PDF = 4;
  localparam int ICSF_B_TO = 5;
  localparam int ICSF_B_GIE = 0;
  localparam int ICSF_B_EIE = 1;
  localparam int ICSF_B_TIE = 2;
  localparam int ICSF_B_EIP = 4;
  localparam int ICSF_B_TIP = 5;
  localparam logic [7:0] ICSF_RST_BYTE = 8'h00;
  localparam logic [10:0] ICSF_VEC_EXT = 11'h004;
  localparam logic [10:0] ICSF_VEC_TMR = 11'h008;
  localparam logic [2:0] ICSF_STACK_DEPTH = 3'h4;
  localparam logic [2:0] ICSF_STACK_EMPTY = 3'h0;

  // ************************************************************
  // Types
  // ************************************************************
  typedef enum logic [2:0] {
    ICSF_OP_NONE, ICSF_OP_ADD, ICSF_OP_SUB, ICSF_OP_LOGIC, ICSF_OP_ROT
  } icsf_op_t;

  // Flag result from the ALU, qualified by op
  typedef struct packed {
    icsf_op_t op;
    logic [7:0] result;
    logic carry_out;
    logic half_carry;
    logic carry_msb_in;
  } icsf_alu_t;

  // Sequencer events, each a one-cycle pulse
  typedef struct packed {
    logic call;
    logic return_plain;
    logic return_enable_irq;
    logic halt;
    logic watchdog_clear_instr;
    logic watchdog_timeout;
  } icsf_seq_t;

  typedef struct packed {
    logic [7:0] status_flags;
    logic [7:0] irq_control;
    logic [2:0] return_stack_index;
    logic pin_s1;
    logic pin_s2;
    logic pin_s3;
    logic ack;
    logic [10:0] vector;
    logic wake;
    logic [7:0] rdata;
  } icsf_state_t;
endpackage : icsf_pkg

// ---- icsf_top.sv ----
// Interrupt control, return stack gating and status flags.
// Assumes sequencer events, ALU results and bus strobes are synchronous.
//
// Our own choice: strobed register access.
`timescale 1ns/100ps
module icsf_top
  import icsf_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic ext_irq_n,
  input wire logic timer_overflow,
  input wire logic phase_two_pulse,
  input wire icsf_alu_t alu,
  input wire icsf_seq_t seq,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  output logic irq_ack,
  output logic [10:0] irq_vector,
  output logic wake,
  output logic stack_full,
  output logic [7:0] status_out,
  output logic [7:0] irq_control_out
);
  icsf_state_t s_r;
  icsf_state_t s_nxt;

  // ************************************************************
  // Next state
  // ************************************************************
  always_comb begin
    logic ext_edge;
    logic ext_go;
    logic tmr_go;
    logic full;
    logic [8:0] st;
    logic [7:0] ic;
    ext_edge = 1'b0;
    ext_go = 1'b0;
    tmr_go = 1'b0;
    full = 1'b0;
    st = 9'h000;
    ic = 8'h00;
    s_nxt = s_r;
    // Two-flop sync then edge on the second and third stage
    s_nxt.pin_s1 = ext_irq_n;
    s_nxt.pin_s2 = s_r.pin_s1;
    s_nxt.pin_s3 = s_r.pin_s2;
    ext_edge = s_r.pin_s3 & ~s_r.pin_s2;
    full = (s_r.return_stack_index == ICSF_STACK_DEPTH);
    ic = s_r.irq_control;
    // Software write first so hardware set wins the same cycle
    if (wr && addr == ICSF_ADDR_IRQ_CONTROL) begin
      ic = wdata & 8'h37;
    end
    // Return-enable pops and re-arms global enable
    if (seq.return_enable_irq) begin
      ic[ICSF_B_GIE] = 1'b1;
    end
    // Gate only at the phase-two edge; full stack holds off
    if (phase_two_pulse && !full && s_r.irq_control[ICSF_B_GIE]) begin
      ext_go = s_r.irq_control[ICSF_B_EIP] & s_r.irq_control[ICSF_B_EIE];
      tmr_go = !ext_go && s_r.irq_control[ICSF_B_TIP]
               && s_r.irq_control[ICSF_B_TIE];
    end
    if (ext_go) begin
      ic[ICSF_B_EIP] = 1'b0;
      ic[ICSF_B_GIE] = 1'b0;
    end
    if (tmr_go) begin
      ic[ICSF_B_TIP] = 1'b0;
      ic[ICSF_B_GIE] = 1'b0;
    end
    // Sets always recorded, enable bits never clear them
    if (ext_edge) begin
      ic[ICSF_B_EIP] = 1'b1;
    end
    if (timer_overflow) begin
      ic[ICSF_B_TIP] = 1'b1;
    end
    s_nxt.irq_control = ic;
    s_nxt.ack = ext_go | tmr_go;
    s_nxt.vector = ext_go ? ICSF_VEC_EXT : (tmr_go ? ICSF_VEC_TMR : s_r.vector);
    s_nxt.wake = ext_edge | timer_overflow;
    // Push on call or acknowledge; only the PC goes, sequencer keeps it
    if ((seq.call || ext_go || tmr_go) && !full) begin
      s_nxt.return_stack_index = s_r.return_stack_index + 3'h1;
    end else if ((seq.return_plain || seq.return_enable_irq)
                 && s_r.return_stack_index != ICSF_STACK_EMPTY) begin
      s_nxt.return_stack_index = s_r.return_stack_index - 3'h1;
    end
    // Arithmetic flags from the ALU; a call on a full stack is not pushed, index holds
    st = {1'b0, s_r.status_flags};
    if (wr && addr == ICSF_ADDR_STATUS) begin
      st[3:0] = wdata[3:0];
    end
    case (alu.op)
      ICSF_OP_ADD, ICSF_OP_SUB: begin
        st[ICSF_B_C] = alu.carry_out;
        st[ICSF_B_AC] = alu.half_carry;
        st[ICSF_B_Z] = (alu.result == 8'h00);
        st[ICSF_B_OV] = alu.carry_msb_in ^ alu.carry_out;
      end
      ICSF_OP_LOGIC: begin
        st[ICSF_B_Z] = (alu.result == 8'h00);
      end
      ICSF_OP_ROT: begin
        st[ICSF_B_C] = alu.carry_out;
      end
      default: begin
      end
    endcase
    if (seq.watchdog_clear_instr) begin
      st[ICSF_B_PDF] = 1'b0;
      st[ICSF_B_TO] = 1'b0;
    end
    if (seq.halt) begin
      st[ICSF_B_PDF] = 1'b1;
      st[ICSF_B_TO] = 1'b0;
    end
    if (seq.watchdog_timeout) begin
      st[ICSF_B_TO] = 1'b1;
    end
    st[7:6] = 2'b00;
    s_nxt.status_flags = st[7:0];
    // Read data valid the cycle after the strobe only
    s_nxt.rdata = 8'h00;
    if (rd && addr == ICSF_ADDR_STATUS) begin
      s_nxt.rdata = s_r.status_flags & 8'h3f;
    end else if (rd && addr == ICSF_ADDR_IRQ_CONTROL) begin
      s_nxt.rdata = s_r.irq_control & 8'h37;
    end
    if (rst) begin
      s_nxt = '0;
      s_nxt.pin_s1 = 1'b1;
      s_nxt.pin_s2 = 1'b1;
      s_nxt.pin_s3 = 1'b1;
      s_nxt.status_flags = ICSF_RST_BYTE;
      s_nxt.irq_control = ICSF_RST_BYTE;
    end
  end

  // ************************************************************
  // State register
  // ************************************************************
  always_ff @(posedge clk) begin
    s_r <= s_nxt;
  end

  // Outputs straight from flops, except stack_full decoded from the index
  assign rdata = s_r.rdata;
  assign irq_ack = s_r.ack;
  assign irq_vector = s_r.vector;
  assign wake = s_r.wake;
  assign stack_full = (s_r.return_stack_index == ICSF_STACK_DEPTH);
  assign status_out = s_r.status_flags;
  assign irq_control_out = s_r.irq_control;

  // ************************************************************
  // Assertions
  // ************************************************************
  property p_ext_set;
    @(posedge clk) disable iff (rst)
      (s_r.pin_s3 && !s_r.pin_s2) |=> s_r.irq_control[ICSF_B_EIP];
  endproperty
  a_ext_set: assert property (p_ext_set) else $error("ext pending not set");

  property p_tmr_set;
    @(posedge clk) disable iff (rst)
      timer_overflow |=> s_r.irq_control[ICSF_B_TIP];
  endproperty
  a_tmr_set: assert property (p_tmr_set) else $error("timer pending not set");

  property p_ext_vec;
    @(posedge clk) disable iff (rst)
      (irq_ack && irq_vector == ICSF_VEC_EXT) |-> !s_r.irq_control[ICSF_B_GIE]
        || $past(seq.return_enable_irq) || $past(wr);
  endproperty
  a_ext_vec: assert property (p_ext_vec) else $error("global left on");

  property p_prio;
    @(posedge clk) disable iff (rst)
      (phase_two_pulse && stack_full == 1'b0 && s_r.irq_control[2:0] == 3'h7
       && s_r.irq_control[ICSF_B_EIP] && s_r.irq_control[ICSF_B_TIP])
      |=> irq_ack && irq_vector == ICSF_VEC_EXT;
  endproperty
  a_prio: assert property (p_prio) else $error("wrong priority");

  property p_tmr_vec;
    @(posedge clk) disable iff (rst)
      (phase_two_pulse && !stack_full && s_r.irq_control[0] && s_r.irq_control[2]
       && s_r.irq_control[ICSF_B_TIP] && !(s_r.irq_control[1] && s_r.irq_control[4]))
      |=> irq_ack && irq_vector == ICSF_VEC_TMR;
  endproperty
  a_tmr_vec: assert property (p_tmr_vec) else $error("timer not served");

  property p_sample;
    @(posedge clk) disable iff (rst)
      !phase_two_pulse |=> !irq_ack;
  endproperty
  a_sample: assert property (p_sample) else $error("ack off phase two");

  property p_full;
    @(posedge clk) disable iff (rst)
      stack_full |=> !irq_ack;
  endproperty
  a_full: assert property (p_full) else $error("ack with full stack");

  property p_return_enable_irq;
    @(posedge clk) disable iff (rst)
      (seq.return_enable_irq && !phase_two_pulse) |=> s_r.irq_control[ICSF_B_GIE];
  endproperty
  a_return_enable_irq: assert property (p_return_enable_irq) else $error("global not re-armed");

  property p_flags_hi;
    @(posedge clk) disable iff (rst)
      1'b1 |-> status_out[7:6] == 2'b00 && irq_control_out[7:6] == 2'b00
        && irq_control_out[3] == 1'b0;
  endproperty
  a_flags_hi: assert property (p_flags_hi) else $error("unused bits set");

  property p_halt;
    @(posedge clk) disable iff (rst)
      (seq.halt && !seq.watchdog_timeout) |=> status_out[4] && !status_out[5];
  endproperty
  a_halt: assert property (p_halt) else $error("halt flags wrong");

  property p_wr_keep;
    @(posedge clk) disable iff (rst)
      (wr && addr == ICSF_ADDR_STATUS && seq == '0) |=> $stable(status_out[5:4]);
  endproperty
  a_wr_keep: assert property (p_wr_keep) else $error("write changed pdf/to");

  // ************************************************************
  // Service, stack and flag detail checks
  // ************************************************************
  // External service clears its pending bit and the global enable
  property p_ext_clr;
    @(posedge clk) disable iff (rst)
      (phase_two_pulse && !stack_full && s_r.irq_control[ICSF_B_GIE]
       && s_r.irq_control[ICSF_B_EIP] && s_r.irq_control[ICSF_B_EIE]
       && !(s_r.pin_s3 && !s_r.pin_s2))
      |=> !s_r.irq_control[ICSF_B_EIP] && !s_r.irq_control[ICSF_B_GIE];
  endproperty
  a_ext_clr: assert property (p_ext_clr) else $error("ext service left flags");

  // Timer service clears its pending bit unless a new overflow lands
  property p_tmr_clr;
    @(posedge clk) disable iff (rst)
      (phase_two_pulse && !stack_full && s_r.irq_control[ICSF_B_GIE]
       && s_r.irq_control[ICSF_B_TIP] && s_r.irq_control[ICSF_B_TIE]
       && !(s_r.irq_control[ICSF_B_EIP] && s_r.irq_control[ICSF_B_EIE])
       && !timer_overflow)
      |=> !s_r.irq_control[ICSF_B_TIP] && !s_r.irq_control[ICSF_B_GIE];
  endproperty
  a_tmr_clr: assert property (p_tmr_clr) else $error("timer service left flags");

  // Global enable off means no acknowledge at all
  property p_gie_off;
    @(posedge clk) disable iff (rst)
      !s_r.irq_control[ICSF_B_GIE] |=> !irq_ack;
  endproperty
  a_gie_off: assert property (p_gie_off) else $error("ack while disabled");

  // Pending external flag persists between sampling points
  property p_ext_keep;
    @(posedge clk) disable iff (rst)
      (s_r.irq_control[ICSF_B_EIP] && !phase_two_pulse
       && !(wr && addr == ICSF_ADDR_IRQ_CONTROL)) |=> s_r.irq_control[ICSF_B_EIP];
  endproperty
  a_ext_keep: assert property (p_ext_keep) else $error("ext pending lost");

  // Pending timer flag persists between sampling points
  property p_tmr_keep;
    @(posedge clk) disable iff (rst)
      (s_r.irq_control[ICSF_B_TIP] && !phase_two_pulse
       && !(wr && addr == ICSF_ADDR_IRQ_CONTROL)) |=> s_r.irq_control[ICSF_B_TIP];
  endproperty
  a_tmr_keep: assert property (p_tmr_keep) else $error("timer pending lost");

  // Timer overflow raises the wake pulse
  property p_wake_tmr;
    @(posedge clk) disable iff (rst)
      timer_overflow |=> wake;
  endproperty
  a_wake_tmr: assert property (p_wake_tmr) else $error("no wake on overflow");

  // Falling pin edge raises the wake pulse
  property p_wake_ext;
    @(posedge clk) disable iff (rst)
      (s_r.pin_s3 && !s_r.pin_s2) |=> wake;
  endproperty
  a_wake_ext: assert property (p_wake_ext) else $error("no wake on pin edge");

  // A call with room pushes exactly one level
  property p_push;
    @(posedge clk) disable iff (rst)
      (seq.call && !stack_full)
      |=> s_r.return_stack_index == $past(s_r.return_stack_index) + 3'h1;
  endproperty
  a_push: assert property (p_push) else $error("call push wrong");

  // A plain return pops one level when not empty
  property p_pop;
    @(posedge clk) disable iff (rst)
      (seq.return_plain && !seq.call && !phase_two_pulse
       && s_r.return_stack_index != ICSF_STACK_EMPTY)
      |=> s_r.return_stack_index == $past(s_r.return_stack_index) - 3'h1;
  endproperty
  a_pop: assert property (p_pop) else $error("return pop wrong");

  // A plain return leaves the global enable alone
  property p_plain_gie;
    @(posedge clk) disable iff (rst)
      (seq.return_plain && !seq.return_enable_irq && !phase_two_pulse
       && !(wr && addr == ICSF_ADDR_IRQ_CONTROL))
      |=> s_r.irq_control[ICSF_B_GIE] == $past(s_r.irq_control[ICSF_B_GIE]);
  endproperty
  a_plain_gie: assert property (p_plain_gie) else $error("plain return moved global");

  // Index never passes the four levels
  property p_depth;
    @(posedge clk) disable iff (rst)
      1'b1 |-> s_r.return_stack_index <= ICSF_STACK_DEPTH;
  endproperty
  a_depth: assert property (p_depth) else $error("stack index overrun");

  // Watchdog clear alone drops both system flags
  property p_wdclr;
    @(posedge clk) disable iff (rst)
      (seq.watchdog_clear_instr && !seq.halt && !seq.watchdog_timeout)
      |=> !status_out[ICSF_B_PDF] && !status_out[ICSF_B_TO];
  endproperty
  a_wdclr: assert property (p_wdclr) else $error("watchdog clear flags wrong");

  // Timeout always sets its flag
  property p_to_set;
    @(posedge clk) disable iff (rst)
      seq.watchdog_timeout |=> status_out[ICSF_B_TO];
  endproperty
  a_to_set: assert property (p_to_set) else $error("timeout flag not set");

  // Logic result zero drives the zero flag
  property p_zero;
    @(posedge clk) disable iff (rst)
      (alu.op == ICSF_OP_LOGIC)
      |=> status_out[ICSF_B_Z] == ($past(alu.result) == 8'h00);
  endproperty
  a_zero: assert property (p_zero) else $error("zero flag wrong");

  // Addition copies carry and half carry
  property p_carry;
    @(posedge clk) disable iff (rst)
      (alu.op == ICSF_OP_ADD)
      |=> status_out[ICSF_B_C] == $past(alu.carry_out)
        && status_out[ICSF_B_AC] == $past(alu.half_carry);
  endproperty
  a_carry: assert property (p_carry) else $error("carry flags wrong");

  // Subtraction overflow from the two top carries
  property p_ov;
    @(posedge clk) disable iff (rst)
      (alu.op == ICSF_OP_SUB)
      |=> status_out[ICSF_B_OV] == ($past(alu.carry_msb_in) ^ $past(alu.carry_out));
  endproperty
  a_ov: assert property (p_ov) else $error("overflow flag wrong");

  // Read data is zero outside the answer cycle
  property p_rd_idle;
    @(posedge clk) disable iff (rst)
      !rd |=> rdata == 8'h00;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("stray read data");

  // Control read returns the masked register
  property p_irq_control_rd;
    @(posedge clk) disable iff (rst)
      (rd && addr == ICSF_ADDR_IRQ_CONTROL) |=> rdata == ($past(irq_control_out) & 8'h37);
  endproperty
  a_irq_control_rd: assert property (p_irq_control_rd) else $error("control read wrong");

  // One pin fall gives a one-cycle edge only
  property p_edge_once;
    @(posedge clk) disable iff (rst)
      (s_r.pin_s3 && !s_r.pin_s2) |=> !(s_r.pin_s3 && !s_r.pin_s2);
  endproperty
  a_edge_once: assert property (p_edge_once) else $error("edge seen twice");

  c_ext_ack: cover property (@(posedge clk) disable iff (rst)
    irq_ack && irq_vector == ICSF_VEC_EXT);
  c_tmr_ack: cover property (@(posedge clk) disable iff (rst)
    irq_ack && irq_vector == ICSF_VEC_TMR);
  c_full_hold: cover property (@(posedge clk) disable iff (rst)
    stack_full && s_r.irq_control[ICSF_B_TIP]);
  c_return_enable_irq: cover property (@(posedge clk) disable iff (rst)
    seq.return_enable_irq && s_r.return_stack_index != ICSF_STACK_EMPTY);
endmodule : icsf_top

// ---- icsf_partner.sv ----
// Far-side model: instruction phase pulse and timer/event counter.
// Assumes the bench starts the counter with a one-cycle kick.
`timescale 1ns/100ps
module icsf_partner (
  input wire logic clk,
  input wire logic rst,
  input wire logic kick,
  output logic phase_two_pulse,
  output logic timer_overflow
);
  logic [1:0] ph_r;
  logic [7:0] cnt_r;
  logic run_r;
  // Four system clocks make one instruction cycle
  always_ff @(posedge clk) begin
    ph_r <= rst ? 2'h0 : ph_r + 2'h1;
    phase_two_pulse <= !rst && (ph_r == 2'h3);
  end
  // Preloaded near the top so the overflow comes soon
  always_ff @(posedge clk) begin
    timer_overflow <= run_r && (cnt_r == 8'hff);
    if (rst) begin
      run_r <= 1'b0;
    end else if (kick) begin
      cnt_r <= 8'hfc;
      run_r <= 1'b1;
    end else if (run_r) begin
      cnt_r <= cnt_r + 8'h01;
      run_r <= (cnt_r != 8'hff);
    end
  end
endmodule : icsf_partner

// ---- testbench.sv ----
// Self-checking bench for the interrupt and status flag block.
// Assumes the far-side model supplies phase pulses and overflows.
`timescale 1ns/100ps
module testbench;
  import icsf_pkg::*;
  logic clk = 1'b0, rst = 1'b1, ext_irq_n = 1'b1, kick = 1'b0;
  logic wr = 1'b0, rd = 1'b0;
  int wake_seen = 0;
  logic [7:0] addr = 8'h00, wdata = 8'h00;
  icsf_alu_t alu = '0;
  icsf_seq_t seq = '0;
  logic phase_two_pulse, timer_overflow, irq_ack, wake, stack_full;
  logic [7:0] rdata, status_out, irq_control_out;
  logic [10:0] irq_vector;
  int err_count = 0, n_compared = 0;
  always #20 clk = ~clk;
  // Count wake pulses mid-cycle, away from the launching edge
  always @(negedge clk) if (wake === 1'b1) wake_seen++;
  icsf_partner u_icsf_partner (.clk(clk), .rst(rst), .kick(kick),
    .phase_two_pulse(phase_two_pulse), .timer_overflow(timer_overflow));
  icsf_top u_icsf_top (.clk(clk), .rst(rst), .ext_irq_n(ext_irq_n),
    .timer_overflow(timer_overflow), .phase_two_pulse(phase_two_pulse),
    .alu(alu), .seq(seq), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .irq_ack(irq_ack), .irq_vector(irq_vector), .wake(wake),
    .stack_full(stack_full), .status_out(status_out),
    .irq_control_out(irq_control_out));
  // ****************************************
  // Tasks
  // ****************************************
  task automatic stop_test();
    if (err_count == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : stop_test
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg
  // Read data stands only in the cycle after the strobe
  task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 check(rdata, exp);
  endtask : rd_reg
  task automatic ev(input icsf_seq_t s);
    @(posedge clk);
    seq <= s;
    @(posedge clk);
    seq <= '0;
  endtask : ev
  task automatic alu_op(input icsf_alu_t a, input logic [7:0] exp);
    @(posedge clk);
    alu <= a;
    @(posedge clk);
    alu <= '0;
    #1 check(status_out, exp);
  endtask : alu_op
  task automatic kick_timer();
    @(posedge clk);
    kick <= 1'b1;
    @(posedge clk);
    kick <= 1'b0;
  endtask : kick_timer
  // Bounded wait; a missing acknowledge ends the run
  task automatic wait_ack(input logic [10:0] vec);
    int i;
    for (i = 0; i < 60 && irq_ack !== 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
    if (i == 60) begin
      err_count++;
      stop_test();
    end else begin
      check(irq_vector, vec);
    end
  endtask : wait_ack
  task automatic no_ack(input int n);
    int hits;
    hits = 0;
    repeat (n) begin
      @(posedge clk);
      #1;
      if (irq_ack !== 1'b0) hits++;
    end
    check(16'(hits), 16'h0000);
  endtask : no_ack
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd_reg(ICSF_ADDR_STATUS, 8'h00);
    wr_reg(8'h0c, 8'hff);
    rd_reg(8'h0c, 8'h00);
    rd_reg(ICSF_ADDR_IRQ_CONTROL, 8'h00);
    wr_reg(ICSF_ADDR_IRQ_CONTROL, 8'hf6);
    no_ack(12);
    rd_reg(ICSF_ADDR_IRQ_CONTROL, 8'h36);
    wr_reg(ICSF_ADDR_IRQ_CONTROL, 8'h00);
    rd_reg(ICSF_ADDR_IRQ_CONTROL, 8'h00);
    wr_reg(ICSF_ADDR_STATUS, 8'hff);
    rd_reg(ICSF_ADDR_STATUS, 8'h0f);
    ev(6'h04);
    rd_reg(ICSF_ADDR_STATUS, 8'h1f);
    ev(6'h01);
    rd_reg(ICSF_ADDR_STATUS, 8'h3f);
    wr_reg(ICSF_ADDR_STATUS, 8'h00);
    rd_reg(ICSF_ADDR_STATUS, 8'h30);
    ev(6'h04);
    rd_reg(ICSF_ADDR_STATUS, 8'h10);
    ev(6'h02);
    rd_reg(ICSF_ADDR_STATUS, 8'h00);
    alu_op('{ICSF_OP_ADD, 8'h00, 1'b1, 1'b1, 1'b0}, 8'h0f);
    alu_op('{ICSF_OP_SUB, 8'h80, 1'b0, 1'b0, 1'b1}, 8'h08);
    alu_op('{ICSF_OP_LOGIC, 8'h00, 1'b1, 1'b1, 1'b1}, 8'h0c);
    alu_op('{ICSF_OP_ROT, 8'h01, 1'b1, 1'b0, 1'b0}, 8'h0d);
    alu_op('{ICSF_OP_SUB, 8'h05, 1'b1, 1'b1, 1'b1}, 8'h03);
    // External then timer service, one at a time
    wr_reg(ICSF_ADDR_IRQ_CONTROL, 8'h03);
    ext_irq_n <= 1'b0;
    wait_ack(ICSF_VEC_EXT);
    check(16'(wake_seen), 16'h0001);
    rd_reg(ICSF_ADDR_IRQ_CONTROL, 8'h02);
    check(irq_control_out, 8'h02);
    check(status_out, 8'h03);
    ext_irq_n <= 1'b1;
    wr_reg(ICSF_ADDR_IRQ_CONTROL, 8'h05);
    kick_timer();
    wait_ack(ICSF_VEC_TMR);
    check(16'(wake_seen), 16'h0002);
    rd_reg(ICSF_ADDR_IRQ_CONTROL, 8'h04);
    // Both pending while globally disabled, then released
    wr_reg(ICSF_ADDR_IRQ_CONTROL, 8'h06);
    ext_irq_n <= 1'b0;
    kick_timer();
    no_ack(16);
    ext_irq_n <= 1'b1;
    rd_reg(ICSF_ADDR_IRQ_CONTROL, 8'h36);
    wr_reg(ICSF_ADDR_IRQ_CONTROL, 8'h37);
    wait_ack(ICSF_VEC_EXT);
    rd_reg(ICSF_ADDR_IRQ_CONTROL, 8'h26);
    ev(6'h08);
    wait_ack(ICSF_VEC_TMR);
    // Fourth level taken by a call blocks service
    ev(6'h20);
    #1 check(stack_full, 1'b1);
    wr_reg(ICSF_ADDR_IRQ_CONTROL, 8'h05);
    kick_timer();
    no_ack(16);
    rd_reg(ICSF_ADDR_IRQ_CONTROL, 8'h25);
    ev(6'h10);
    wait_ack(ICSF_VEC_TMR);
    ev(6'h10);
    rd_reg(ICSF_ADDR_IRQ_CONTROL, 8'h04);
    stop_test();
  end
endmodule : testbench
